// ---- lvds_ddr_sample_input_port.sv ----
`timescale 1ns/10ps
// Function
// - capture all sixteen data lanes on both rising and falling link clock edges
// - byte-wide or word-wide mode; upper lanes ignored in byte-wide mode
// - lane 15 word MSB, lane 7 byte MSB, lane 0 LSB unless bus reversal is set
// - bus-reversal bit swaps lane order, MSB to LSB and back
// - frame marker sampled on rising edge resets FIFO or acts as sync
// - frame marker sampled on falling edge usable as block parity bit
// - optional parity lane accompanies data; may be left unconnected
module lvds_ddr_sample_input_port (
  input  wire logic        ref_clk_i,           // 40 MHz system clock
  input  wire logic        reset_i,             // async reset, active high
  input  wire logic        source_sync_clock,   // link clock from source
  input  wire logic [15:0] data_lanes_i,        // differential data lanes
  input  wire logic        frame_marker_input,  // frame indicator
  input  wire logic        parity_lane_input,   // optional parity lane
  input  wire logic        byte_mode_i,         // 1: byte-wide, 0: word-wide
  input  wire logic        reverse_bus_i,       // 1: reverse lane order
  input  wire logic        frame_as_sync_i,     // 1: rise frame is sync, 0: fifo reset
  output logic [15:0]      sample_o,            // assembled sample
  output logic             sample_valid_o,      // one-cycle sample strobe
  output logic             sample_parity_o,     // parity lane with sample
  output logic             fifo_reset_o,        // one-cycle fifo reset pulse
  output logic             sync_pulse_o,        // one-cycle sync pulse
  output logic             block_parity_o,      // falling-edge frame sample
  output logic             block_parity_valid_o // one-cycle strobe for it
);
  localparam int unsigned W = lvds_ddr_pkg::BUS_W;
  localparam int unsigned B = lvds_ddr_pkg::BYTE_W;

  if (lvds_ddr_pkg::CLK_HZ / 1_000_000 * lvds_ddr_pkg::LINK_NS < 4_000)
  begin : g_rate_check
    $error("link clock too fast for edge sampling");
  end

  // all pin inputs and the link clock pass two flip-flops first
  logic [W+2:0] pins_s;
  lvds_ddr_sync #(.WIDTH(W + 3)) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   ({source_sync_clock, parity_lane_input, frame_marker_input, data_lanes_i}),
    .sync_o    (pins_s)
  );

  logic [W-1:0] data_s;
  logic         frame_s;
  logic         parity_s;
  logic         lclk_s;
  logic         lclk_q;
  logic         rise_e;
  logic         fall_e;

  assign data_s   = pins_s[W-1:0];
  assign frame_s  = pins_s[W];
  assign parity_s = pins_s[W+1];
  assign lclk_s   = pins_s[W+2];

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      lclk_q <= 1'b0;
    else
      lclk_q <= lclk_s;
  end

  assign rise_e = lclk_s & ~lclk_q;
  assign fall_e = ~lclk_s & lclk_q;

  // lane order, masking and reversal
  logic [W-1:0] lanes_d;
  always_comb
  begin
    lanes_d = data_s;
    if (byte_mode_i)
    begin
      lanes_d = {{(W-B){1'b0}}, data_s[B-1:0]};
      if (reverse_bus_i)
        for (int i = 0; i < B; i++)
          lanes_d[i] = data_s[B-1-i];
    end
    else if (reverse_bus_i)
    begin
      for (int i = 0; i < W; i++)
        lanes_d[i] = data_s[W-1-i];
    end
  end

  // byte pairing: first capture is the high byte
  logic         half_q;
  logic [B-1:0] hi_byte_q;
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      half_q    <= 1'b0;
      hi_byte_q <= '0;
    end
    else if (rise_e && frame_s && !frame_as_sync_i)
      half_q <= 1'b0;  // frame realigns pairing
    else if (byte_mode_i && (rise_e || fall_e))
    begin
      half_q <= ~half_q;
      if (!half_q)
        hi_byte_q <= lanes_d[B-1:0];
    end
    else if (!byte_mode_i)
      half_q <= 1'b0;
  end

  // sample output on every link edge in word mode, every second edge in byte mode
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sample_o        <= lvds_ddr_pkg::SAMPLE_RST;
      sample_valid_o  <= 1'b0;
      sample_parity_o <= 1'b0;
    end
    else
    begin
      sample_valid_o <= 1'b0;
      if (rise_e || fall_e)
      begin
        sample_parity_o <= parity_s;
        if (!byte_mode_i)
        begin
          sample_o       <= lanes_d;
          sample_valid_o <= 1'b1;
        end
        else if (half_q)
        begin
          sample_o       <= {hi_byte_q, lanes_d[B-1:0]};
          sample_valid_o <= 1'b1;
        end
      end
    end
  end

  // frame marker: rising-edge use
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fifo_reset_o <= 1'b0;
      sync_pulse_o <= 1'b0;
    end
    else
    begin
      fifo_reset_o <= rise_e & frame_s & ~frame_as_sync_i;
      sync_pulse_o <= rise_e & frame_s & frame_as_sync_i;
    end
  end

  // frame marker: falling-edge use as parity
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      block_parity_o       <= 1'b0;
      block_parity_valid_o <= 1'b0;
    end
    else
    begin
      block_parity_valid_o <= fall_e;
      if (fall_e)
        block_parity_o <= frame_s;
    end
  end

  // checks
  a_word_capture: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ((rise_e || fall_e) && !byte_mode_i) |=> sample_valid_o)
    else $error("word capture missed a link edge");

  a_quiet_link: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !(rise_e || fall_e) |=> !sample_valid_o && !block_parity_valid_o)
    else $error("strobe without a link edge");

  a_byte_mask: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    byte_mode_i |-> lanes_d[W-1:B] == '0)
    else $error("upper lanes leaked in byte mode");

  a_reverse_word: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (reverse_bus_i && !byte_mode_i)
      |-> (lanes_d[0] == data_s[W-1] && lanes_d[W-1] == data_s[0]))
    else $error("word reversal wrong");

  a_reverse_byte: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (reverse_bus_i && byte_mode_i) |-> (lanes_d[0] == data_s[B-1] && lanes_d[B-1] == data_s[0]))
    else $error("byte reversal wrong");

  a_lane_order: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!reverse_bus_i && byte_mode_i) |-> lanes_d[B-1:0] == data_s[B-1:0])
    else $error("byte lane order wrong");

  a_fifo_reset: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rise_e && frame_s && !frame_as_sync_i) |=> fifo_reset_o && !sync_pulse_o)
    else $error("fifo reset not raised");

  a_sync_raise: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rise_e && frame_s && frame_as_sync_i) |=> sync_pulse_o && !fifo_reset_o)
    else $error("sync pulse not raised");

  a_sync_pulse: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    sync_pulse_o |-> $past(rise_e) && $past(frame_s) && $past(frame_as_sync_i))
    else $error("sync pulse without cause");

  a_block_parity: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    fall_e |=> block_parity_valid_o && block_parity_o == $past(frame_s))
    else $error("block parity not captured");

  a_parity_pass: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rise_e || fall_e) |=> sample_parity_o == $past(parity_s))
    else $error("parity lane not carried");

  a_byte_first: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (byte_mode_i && (rise_e || fall_e) && !half_q) |=> !sample_valid_o)
    else $error("sample strobed on a first byte");

  a_byte_pair: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (byte_mode_i && sample_valid_o) |-> sample_o[B-1:0] == $past(lanes_d[B-1:0]))
    else $error("byte pair low half wrong");
endmodule

// ---- lvds_ddr_pkg.sv ----
package lvds_ddr_pkg;
  localparam int unsigned BUS_W     = 16;   // data lanes
  localparam int unsigned BYTE_W    = 8;    // lanes used in byte-wide mode
  localparam int unsigned SYNC_W    = 2;    // synchroniser depth
  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam int unsigned LINK_NS   = 200;  // bench link clock period
  localparam logic [15:0] SAMPLE_RST = 16'h0000;
endpackage

// ---- lvds_ddr_sync.sv ----
`timescale 1ns/10ps
// two-stage synchroniser, one per bit
module lvds_ddr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk_i,  // sampling clock
  input  wire logic             reset_i,    // async, active high
  input  wire logic [WIDTH-1:0] async_i,    // asynchronous input
  output logic      [WIDTH-1:0] sync_o      // synchronised output
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1)
  begin : g_width_check
    $error("sync width must be at least one");
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// ---- lvds_src.sv ----
`timescale 1ns/10ps
module lvds_src (
  output logic        link_clk_o, // link clock, still between transfers
  output logic [15:0] lanes_o,    // data lanes
  output logic        frame_o,    // frame marker
  output logic        par_o       // parity lane
);
  initial
  begin
    link_clk_o = 1'b0;
    lanes_o    = 16'h0000;
    frame_o    = 1'b0;
    par_o      = 1'b0;
  end
  // one link edge, lanes and marker change together half-way before it
  task automatic send(input logic [15:0] d, input logic f, input logic p);
    lanes_o = d;
    frame_o = f;
    par_o   = p;
    #50;
    link_clk_o = ~link_clk_o;
    #50;
  endtask
  // released lines show the inverse of the last value
  task automatic idle();
    lanes_o = ~lanes_o;
    frame_o = ~frame_o;
    par_o   = ~par_o;
  endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb;
  logic        ref_clk_i = 1'b0, reset_i = 1'b1, byte_mode_i = 1'b0;
  logic        reverse_bus_i = 1'b0, frame_as_sync_i = 1'b0;
  logic        link_clk, frame, par, s_valid, s_par, f_rst, s_pulse, bp, bp_valid, got_p, got_bp;
  logic [15:0] lanes, sample, got_s;
  int          fails, check_count, n_val, n_fifo, n_sync, n_bp;
  always #12.5 ref_clk_i = ~ref_clk_i;
  lvds_src i_src (.link_clk_o(link_clk), .lanes_o(lanes), .frame_o(frame), .par_o(par));
  lvds_ddr_sample_input_port i_dut (.ref_clk_i, .reset_i, .source_sync_clock(link_clk),
    .data_lanes_i(lanes), .frame_marker_input(frame), .parity_lane_input(par), .byte_mode_i,
    .reverse_bus_i, .frame_as_sync_i, .sample_o(sample), .sample_valid_o(s_valid),
    .sample_parity_o(s_par), .fifo_reset_o(f_rst), .sync_pulse_o(s_pulse),
    .block_parity_o(bp), .block_parity_valid_o(bp_valid));
  always @(posedge ref_clk_i)
  begin
    n_val  += int'(s_valid === 1'b1);
    n_fifo += int'(f_rst === 1'b1);
    n_sync += int'(s_pulse === 1'b1);
    n_bp   += int'(bp_valid === 1'b1);
    if (s_valid === 1'b1) got_s = sample;
    if (s_valid === 1'b1) got_p = s_par;
    if (bp_valid === 1'b1) got_bp = bp;
  end
  task automatic wrap_up();
    $display("fails=%0d checks=%0d", fails, check_count);
    if (fails == 0 && check_count > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic clr();
    i_src.idle();
    n_val = 0;
    n_fifo = 0;
    n_sync = 0;
    n_bp = 0;
    @(negedge ref_clk_i);
  endtask
  // one link edge, then bounded wait until n samples have been seen
  task automatic edge_wait(input logic [15:0] d, input logic f, p, input int n);
    i_src.send(d, f, p);
    for (int i = 0; i < 20 && n_val < n; i++) @(negedge ref_clk_i);
    if (n_val < n)
    begin
      fails++;
      $display("[FAIL] %0t no sample", $time);
      wrap_up();
    end
    repeat (2) @(negedge ref_clk_i);
  endtask
  task automatic word_mode();
    clr();
    edge_wait(16'hA5C3, 1'b1, 1'b1, 1);
    `CHK(got_s, 16'hA5C3)
    `CHK(got_p, 1'b1)
    `CHK(n_fifo, 1)
    edge_wait(16'h3C5A, 1'b1, 1'b0, 2);
    `CHK(got_s, 16'h3C5A)
    `CHK(got_bp, 1'b1)
    `CHK(n_bp, 1)
    `CHK(n_fifo + n_sync, 1)
  endtask
  task automatic sync_rev();
    clr();
    frame_as_sync_i = 1'b1;
    reverse_bus_i = 1'b1;
    edge_wait(16'h0003, 1'b1, 1'b0, 1);
    `CHK(got_s, 16'hC000)
    `CHK(n_sync, 1)
    `CHK(n_fifo, 0)
    edge_wait(16'h1234, 1'b0, 1'b1, 2);
    `CHK(got_s, 16'h2C48)
    `CHK(got_p, 1'b1)
    `CHK(got_bp, 1'b0)
  endtask
  task automatic byte_mode();
    reset_i = 1'b1;
    frame_as_sync_i = 1'b0;
    reverse_bus_i = 1'b0;
    byte_mode_i = 1'b1;
    @(negedge ref_clk_i);
    reset_i = 1'b0;
    clr();
    edge_wait(16'hEE12, 1'b0, 1'b0, 0);
    edge_wait(16'hDD34, 1'b0, 1'b0, 1);
    `CHK(got_s, 16'h1234)
    reverse_bus_i = 1'b1;
    edge_wait(16'h7701, 1'b0, 1'b0, 1);
    edge_wait(16'h6680, 1'b0, 1'b0, 2);
    `CHK(got_s, 16'h8001)
    `CHK(n_val, 2)
    // frame on a rising edge drops that byte and restarts pairing
    reverse_bus_i = 1'b0;
    edge_wait(16'h00AA, 1'b1, 1'b0, 2);
    edge_wait(16'h0056, 1'b0, 1'b0, 2);
    edge_wait(16'h0078, 1'b0, 1'b0, 3);
    `CHK(got_s, 16'h5678)
    `CHK(n_fifo, 1)
    `CHK(n_val, 3)
  endtask
  initial
  begin
    repeat (6) @(negedge ref_clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    word_mode();
    sync_rev();
    byte_mode();
    wrap_up();
  end
endmodule
